// ==== qcr_counter.sv ====
// quadrature counter channel with AHB-Lite register slave
// assumes a single AHB-Lite master; encoder lines arrive unsynchronised
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`default_nettype none
`timescale 1ns/1ps

// Notes on behaviour
// - single precision counts on phase A rise
// - double precision counts both phase A edges
// - quad precision counts every A and B edge
// - precision defaults to single after reset
// - direction from four combined phase states
// - reset input clears counter on each pulse
// - non-inverted reset: high level zeroes count
// - count only while reset low; hold while high
// - angle equals count times multiplier plus offset
// - counting only with 18-bit recorder resolution set
module qcr_counter import qcr_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic phaseAInput,
    input wire logic phaseBInput,
    input wire logic refInput
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] count;
        logic [31:0] mult;
        logic [31:0] offset;
        logic [31:0] hrdata;
        logic [7:0] addr;
        logic wrPend;
        logic rdPend;
        logic [1:0] prevAB;
        logic primed;
        logic skipErr;
    } qcr_state_t;

    localparam qcr_state_t ST_RESET = '{
        ctrl: CTRL_RESET,
        count: 32'h0,
        mult: MULT_RESET,
        offset: OFFSET_RESET,
        hrdata: 32'h0,
        addr: 8'h0,
        wrPend: 1'b0,
        rdPend: 1'b0,
        prevAB: 2'h0,
        primed: 1'b0,
        skipErr: 1'b0
    };

    qcr_state_t st_q;
    qcr_state_t st_d;

    logic [2:0] syncIn;
    logic signed [63:0] angle;
    logic aNew;
    logic bNew;
    logic refNew;
    logic aChg;
    logic bChg;
    logic upDir;
    logic step;
    logic holdZero;
    logic res18;
    logic counting;
    logic accept;
    logic [1:0] prec;
    logic [31:0] rdWord;

    // ==========================================================
    // input synchroniser and angle scaler
    qcr_sync #(
        .W(3)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din({refInput, phaseBInput, phaseAInput}),
        .dout(syncIn)
    );

    qcr_scale u_scale (
        .clock(clock),
        .rst_n(rst_n),
        .count(st_q.count),
        .mult(st_q.mult),
        .offset(st_q.offset),
        .angle(angle)
    );

    // ==========================================================
    // decode of the synchronised phases
    always_comb begin
        aNew = syncIn[0];
        bNew = syncIn[1];
        refNew = syncIn[2];
        prec = st_q.ctrl[CTRL_PREC_LSB +: 2];
        res18 = st_q.ctrl[CTRL_RES18_BIT];
        // primed stops a spurious edge against the reset value of prevAB
        aChg = st_q.primed && (aNew != st_q.prevAB[0]);
        bChg = st_q.primed && (bNew != st_q.prevAB[1]);
        // gray walk 00-10-11-01 is A leading; new A vs old B gives the sense
        upDir = aNew ^ st_q.prevAB[1];
        // code 3 is undefined and falls to the quad arm
        case (prec)
            PREC_SINGLE: step = aChg && aNew && !bChg;
            PREC_DOUBLE: step = aChg && !bChg;
            default: step = aChg ^ bChg;
        endcase
        holdZero = st_q.ctrl[CTRL_RSTEN_BIT] && (refNew ^ st_q.ctrl[CTRL_INV_BIT]);
        counting = res18 && !holdZero;
    end

    // ==========================================================
    // bus address phase and read data
    // angle halves are not latched together; software must read them
    // while count, multiplier and offset stand still
    assign accept = hsel && hready && htrans[1];

    always_comb begin
        case (st_q.addr)
            OFF_CTRL: rdWord = st_q.ctrl;
            OFF_COUNT: rdWord = st_q.count;
            OFF_MULT: rdWord = st_q.mult;
            OFF_OFFSET: rdWord = st_q.offset;
            OFF_ANGLE_LO: rdWord = angle[31:0];
            OFF_ANGLE_HI: rdWord = angle[63:32];
            OFF_STATUS: begin
                rdWord = 32'h0;
                rdWord[ST_PHA_BIT] = aNew;
                rdWord[ST_PHB_BIT] = bNew;
                rdWord[ST_REF_BIT] = refNew;
                rdWord[ST_HOLD_BIT] = holdZero;
                rdWord[ST_SKIP_BIT] = st_q.skipErr;
            end
            default: rdWord = 32'h0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.prevAB = {bNew, aNew};
        st_d.primed = 1'b1;

        if (!res18) begin
            st_d.count = st_q.count;
        end else if (holdZero) begin
            st_d.count = 32'h0;
        end else if (step) begin
            st_d.count = upDir ? st_q.count + 32'h1 : st_q.count - 32'h1;
        end

        // register writes land at the end of the data phase
        if (st_q.wrPend) begin
            case (st_q.addr)
                OFF_CTRL: st_d.ctrl = hwdata & CTRL_MASK;
                OFF_MULT: st_d.mult = hwdata;
                OFF_OFFSET: st_d.offset = hwdata;
                OFF_STATUS: begin
                    if (hwdata[ST_SKIP_BIT]) begin
                        st_d.skipErr = 1'b0;
                    end
                end
                default: st_d.skipErr = st_q.skipErr;
            endcase
        end
        // both phases moving in one cycle is lost; set beats a clear
        if (aChg && bChg && res18) begin
            st_d.skipErr = 1'b1;
        end

        // reads take one wait state so read data always come from a flop
        if (st_q.rdPend) begin
            st_d.hrdata = rdWord;
        end
        st_d.wrPend = accept && hwrite && (hsize == HSIZE_WORD);
        st_d.rdPend = accept && !hwrite;
        if (accept) begin
            st_d.addr = haddr[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout = !st_q.rdPend;
    assign hresp = 1'b0;
    assign hrdata = st_q.hrdata;

    // ==========================================================
    // checks
    chk_single_rise_only: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_SINGLE && !(aChg && aNew))
            |=> (st_q.count == $past(st_q.count)))
        else $error("single precision counted without a phase A rise");

    chk_double_both_edges: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_DOUBLE && aChg && !bChg)
            |=> (st_q.count != $past(st_q.count)))
        else $error("double precision missed a phase A edge");

    chk_quad_b_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_QUAD && bChg && !aChg)
            |=> (st_q.count != $past(st_q.count)))
        else $error("quad precision missed a phase B edge");

    chk_default_single: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (st_q.ctrl[CTRL_PREC_LSB +: 2] == PREC_SINGLE && st_q.count == 32'h0))
        else $error("precision not single after reset");

    chk_up_when_leading: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_QUAD && aChg && !bChg && aNew != st_q.prevAB[1])
            |=> (st_q.count == $past(st_q.count) + 32'h1))
        else $error("phase A leading did not count up");

    chk_hold_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        (res18 && holdZero) [*2] |=> (st_q.count == 32'h0) && $stable(st_q.count))
        else $error("count not held at zero while reset active");

    chk_res18_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !res18 |=> $stable(st_q.count))
        else $error("counter moved without 18-bit resolution");

    chk_read_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && !hwrite) |=> !hreadyout ##1 (hreadyout && hrdata == $past(rdWord)))
        else $error("read did not complete after one wait state");

    // ==========================================================
    // checks on counting, direction, clearing, skips and bus writes

    chk_single_rise_counts: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_SINGLE && aChg && aNew && !bChg)
            |=> (st_q.count != $past(st_q.count)))
        else $error("single precision missed a phase A rise");

    chk_double_b_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_DOUBLE && bChg && !aChg)
            |=> (st_q.count == $past(st_q.count)))
        else $error("double precision counted a phase B edge");

    chk_quad_a_edge: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec[1] && aChg && !bChg)
            |=> (st_q.count != $past(st_q.count)))
        else $error("quad precision missed a phase A edge");

    chk_down_when_lagging: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && prec == PREC_QUAD && aChg && !bChg && aNew == st_q.prevAB[1])
            |=> (st_q.count == $past(st_q.count) - 32'h1))
        else $error("phase A lagging did not count down");

    chk_pulse_clears: assert property (@(posedge clock) disable iff (!rst_n)
        (res18 && holdZero) |=> (st_q.count == 32'h0))
        else $error("reset input did not clear the count");

    chk_inverted_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (res18 && st_q.ctrl[CTRL_RSTEN_BIT] && st_q.ctrl[CTRL_INV_BIT] && !refNew)
            |=> (st_q.count == 32'h0))
        else $error("inverted reset level did not clear the count");

    chk_hold_released: assert property (@(posedge clock) disable iff (!rst_n)
        (res18 && !holdZero && step) |=> (st_q.count != $past(st_q.count)))
        else $error("count did not resume after reset released");

    chk_both_lines_lost: assert property (@(posedge clock) disable iff (!rst_n)
        (counting && aChg && bChg) |=> (st_q.count == $past(st_q.count)))
        else $error("simultaneous phase change was counted");

    chk_skip_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        (res18 && aChg && bChg) |=> st_q.skipErr)
        else $error("skip error not flagged on a double phase change");

    chk_ctrl_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
        (st_q.wrPend && st_q.addr == OFF_CTRL)
            |=> (st_q.ctrl == $past(hwdata & CTRL_MASK)))
        else $error("control write did not land");

    chk_write_no_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && hwrite) |=> hreadyout)
        else $error("write data phase was stretched");
endmodule : qcr_counter

`default_nettype wire

// ==== qcr_pkg.sv ====
// constants shared by the quadrature counter channel
// assumes one 250 MHz clock and a synchronous active-low reset
`default_nettype none

package qcr_pkg;
    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_MULT = 8'h08;
    localparam logic [7:0] OFF_OFFSET = 8'h0c;
    localparam logic [7:0] OFF_ANGLE_LO = 8'h10;
    localparam logic [7:0] OFF_ANGLE_HI = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // ==========================================================
    // control fields
    localparam int CTRL_PREC_LSB = 0;
    localparam int CTRL_RSTEN_BIT = 2;
    localparam int CTRL_INV_BIT = 3;
    localparam int CTRL_RES18_BIT = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0000_001f;

    // precision codes; the unused code behaves as quad
    localparam logic [1:0] PREC_SINGLE = 2'h0;
    localparam logic [1:0] PREC_DOUBLE = 2'h1;
    localparam logic [1:0] PREC_QUAD = 2'h2;

    // ==========================================================
    // status fields
    localparam int ST_PHA_BIT = 0;
    localparam int ST_PHB_BIT = 1;
    localparam int ST_REF_BIT = 2;
    localparam int ST_HOLD_BIT = 3;
    localparam int ST_SKIP_BIT = 4;

    // ==========================================================
    // reset values; multiplier in micro-degrees per count
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [31:0] MULT_RESET = 32'h0001_5753;
    localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;

    // AHB and synchroniser constants
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int SYNC_STAGES = 2;
endpackage : qcr_pkg

`default_nettype wire

// ==== qcr_sync.sv ====
// two-flop synchroniser for a vector of level inputs
// assumes inputs asynchronous to clock, each bit independent
`default_nettype none
`timescale 1ns/1ps

module qcr_sync import qcr_pkg::*; #(
    parameter int W = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } qcr_sync_state_t;

    qcr_sync_state_t st_q;
    qcr_sync_state_t st_d;

    always_comb begin
        st_d.meta = din;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.stable;

    // ==========================================================
    // checks
    chk_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(rst_n) && $past(rst_n, 2)) |-> (dout == $past(din, SYNC_STAGES)))
        else $error("synchroniser latency is not two cycles");
endmodule : qcr_sync

`default_nettype wire

// ==== qcr_scale.sv ====
// angle scaling: count times multiplier plus offset, two-cycle pipeline
// assumes operands change at most once per cycle; result is 64-bit signed
`default_nettype none
`timescale 1ns/1ps

module qcr_scale import qcr_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic signed [31:0] count,
    input wire logic signed [31:0] mult,
    input wire logic signed [31:0] offset,
    output logic signed [63:0] angle
);
    typedef struct packed {
        logic signed [63:0] prod;
        logic signed [31:0] off;
        logic signed [63:0] angle;
    } qcr_scale_state_t;

    qcr_scale_state_t st_q;
    qcr_scale_state_t st_d;
    logic signed [63:0] angleRef;

    // pipelined so the multiplier does not sit in one 4 ns path with the add
    always_comb begin
        st_d.prod = 64'(count) * 64'(mult);
        st_d.off = offset;
        st_d.angle = $signed(st_q.prod) + 64'($signed(st_q.off));
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign angle = st_q.angle;
    assign angleRef = 64'(count) * 64'(mult) + 64'(offset);

    // ==========================================================
    // checks
    chk_scale_angle: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(rst_n) && $past(rst_n, 2)) |-> (angle == $past(angleRef, 2)))
        else $error("angle is not count times multiplier plus offset");
endmodule : qcr_scale

`default_nettype wire

// ==== qcr_encoder_model.sv ====
// behavioural incremental encoder driving the counter's three encoder pins
// assumes the bench calls its tasks; pins change just after a rising clock edge
`default_nettype none
`timescale 1ns/1ps

module qcr_encoder_model import qcr_pkg::*; (
    input wire logic clock,
    output logic phaseAInput,
    output logic phaseBInput,
    output logic refInput
);
    // ==========================================================
    // gray position: 00 -> 10 -> 11 -> 01 going up, so A leads B
    logic [1:0] pos = 2'h0;
    logic refQ = 1'b0;

    assign phaseAInput = (pos == 2'h1) || (pos == 2'h2);
    assign phaseBInput = pos[1];
    assign refInput = refQ;

    // ==========================================================
    // one line changes per step, three clocks apart, never both at once
    task automatic move(input bit up, input int cycles);
        repeat (cycles * 4) begin
            repeat (3) @(posedge clock);
            pos <= up ? pos + 2'h1 : pos - 2'h1;
        end
    endtask : move

    task automatic pulse(input int len);
        @(posedge clock);
        refQ <= 1'b1;
        repeat (len) @(posedge clock);
        refQ <= 1'b0;
    endtask : pulse

    // both lines flip together; breaks the one-line order on purpose
    task automatic jump();
        @(posedge clock);
        pos <= pos + 2'h2;
    endtask : jump

    task automatic setRef(input bit v);
        @(posedge clock);
        refQ <= v;
    endtask : setRef
endmodule : qcr_encoder_model

`default_nettype wire

// ==== qcr_counter_bench.sv ====
// self-checking bench for the quadrature counter channel
// assumes one AHB-Lite slave, hready fed back from hreadyout
`default_nettype none
`timescale 1ns/1ps

module qcr_counter_bench import qcr_pkg::*;;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic phA;
    wire logic phB;
    wire logic refLine;
    logic [31:0] rdData;
    logic rspSeen;
    logic [31:0] expQ[$];
    string nameQ[$];
    event rdEvt;
    int nMismatch = 0;
    int cmpCount = 0;

    always #2 clock = ~clock;

    qcr_counter uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .phaseAInput(phA), .phaseBInput(phB), .refInput(refLine));

    qcr_encoder_model enc (.clock(clock), .phaseAInput(phA), .phaseBInput(phB),
        .refInput(refLine));

    // ==========================================================
    // verdict and comparison
    task automatic conclude();
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // watcher takes the oldest note whenever a read completes
    always begin
        @(rdEvt);
        check(nameQ.pop_front(), rdData, expQ.pop_front());
        check("hresp", {31'h0, rspSeen}, 32'h0);
    end

    // ==========================================================
    // AHB-Lite master
    task automatic waitRdy();
        for (int i = 0; i < 40; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) return;
        end
        nMismatch++;
        conclude();
    endtask : waitRdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rdData = hrdata;
        rspSeen = hresp;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        nameQ.push_back(what);
        bus(1'b0, a, 32'h0);
        ->rdEvt;
    endtask : rd

    // pin change to count is three edges, angle two more
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask : settle

    // ==========================================================
    // main sequence
    initial begin
        int n;
        int k;
        logic [31:0] m;
        logic [31:0] o;
        longint ang;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        void'($urandom(35207));
        rd("ctrl", OFF_CTRL, CTRL_RESET);
        rd("mult", OFF_MULT, MULT_RESET);
        rd("offset", OFF_OFFSET, 32'h0);
        rd("unmapped", 8'h1c, 32'h0);
        enc.move(1, 1);
        settle();
        rd("count", OFF_COUNT, 32'h0);
        // every precision code, cleared by a reference pulse first
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CTRL, 32'h14 | p);
            enc.pulse(2);
            settle();
            rd("count", OFF_COUNT, 32'h0);
            n = 1 + $urandom % 3;
            k = (p == 0) ? 1 : ((p == 1) ? 2 : 4);
            enc.move(1, n);
            settle();
            rd("count", OFF_COUNT, n * k);
            enc.move(0, 1);
            settle();
            rd("count", OFF_COUNT, (n - 1) * k);
        end
        wr(OFF_CTRL, 32'h16);
        enc.setRef(1'b1);
        enc.move(1, 1);
        settle();
        rd("count", OFF_COUNT, 32'h0);
        rd("status", OFF_STATUS, 32'h0c);
        enc.setRef(1'b0);
        enc.move(1, 1);
        settle();
        rd("count", OFF_COUNT, 32'h4);
        // inverted polarity: low reference now holds the count
        wr(OFF_CTRL, 32'h1e);
        settle();
        rd("count", OFF_COUNT, 32'h0);
        enc.setRef(1'b1);
        enc.move(1, 1);
        settle();
        rd("count", OFF_COUNT, 32'h4);
        wr(OFF_COUNT, 32'h55);
        rd("count", OFF_COUNT, 32'h4);
        wr(OFF_CTRL, 32'h12);
        m = $urandom % 200000;
        o = $urandom;
        wr(OFF_MULT, m);
        wr(OFF_OFFSET, o);
        enc.move(1, 1);
        settle();
        ang = 64'sd8 * longint'($signed(m)) + longint'($signed(o));
        rd("angle lo", OFF_ANGLE_LO, ang[31:0]);
        rd("angle hi", OFF_ANGLE_HI, ang[63:32]);
        // both lines at once: no count, sticky skip flag, cleared by writing a one
        enc.jump();
        settle();
        rd("count", OFF_COUNT, 32'h8);
        rd("status", OFF_STATUS, 32'h17);
        wr(OFF_STATUS, 32'h10);
        rd("status", OFF_STATUS, 32'h07);
        @(posedge clock);
        conclude();
    end
endmodule : qcr_counter_bench

`default_nettype wire
